/* pmr_core.sv */
// Bus master core: single-data 32-bit read sequencing toward the bus and the local master.
// Assumes bus lines, arbiter grant and local inputs are all synchronous to CLK_SYS.
`timescale 1ns/100ps
`default_nettype none
module pmr_core (
    input  wire logic CLK_SYS,
    input  wire logic NRST,
    input  wire logic CE,
    input  wire logic GNT_N,
    output logic      REQ_N,
    pmr_link_if.dev   LINK
);
    import pmr_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {S_IDLE, S_REQ, S_GRANT, S_LOAD, S_ADDR, S_DATA, S_TERM} pmr_state_t;

    pmr_state_t state_q;
    pmr_state_t state_d;
    logic       req_n_q;
    logic       req_n_d;
    logic       grant_n_q;
    logic       grant_n_d;
    pmr_nib_t   status_q;
    pmr_nib_t   status_d;
    pmr_nib_t   end_q;
    pmr_nib_t   end_d;
    pmr_word_t  addr_q;
    pmr_word_t  addr_d;
    pmr_nib_t   cmd_q;
    pmr_nib_t   cmd_d;
    pmr_len_t   len_q;
    pmr_len_t   len_d;
    pmr_len_t   cnt_q;
    pmr_len_t   cnt_d;
    logic       frame_o_q;
    logic       frame_o_d;
    logic       frame_oe_q;
    logic       frame_oe_d;
    logic       irdy_o_q;
    logic       irdy_o_d;
    logic       irdy_oe_q;
    logic       irdy_oe_d;
    pmr_word_t  ad_o_q;
    pmr_word_t  ad_o_d;
    logic       ad_oe_q;
    logic       ad_oe_d;
    pmr_nib_t   cbe_o_q;
    pmr_nib_t   cbe_o_d;
    logic       cbe_oe_q;
    logic       cbe_oe_d;
    pmr_word_t  data_q;
    pmr_word_t  data_d;
    logic       strobe_n_q;
    logic       strobe_n_d;
    logic       bus_idle;
    logic       phase_done;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        state_d    = state_q;
        req_n_d    = req_n_q;
        grant_n_d  = grant_n_q;
        status_d   = status_q;
        end_d      = end_q;
        addr_d     = addr_q;
        cmd_d      = cmd_q;
        len_d      = len_q;
        cnt_d      = cnt_q;
        frame_o_d  = frame_o_q;
        frame_oe_d = frame_oe_q;
        irdy_o_d   = irdy_o_q;
        irdy_oe_d  = irdy_oe_q;
        ad_o_d     = ad_o_q;
        ad_oe_d    = ad_oe_q;
        cbe_o_d    = cbe_o_q;
        cbe_oe_d   = cbe_oe_q;
        data_d     = data_q;
        strobe_n_d = strobe_n_q;
        bus_idle   = (LINK.frame_n == IDLE_N) && (LINK.irdy_n == IDLE_N);
        phase_done = (irdy_o_q == ASRT_N) && irdy_oe_q && (LINK.trdy_n == ASRT_N);

        if (grant_n_q == ASRT_N) begin
            grant_n_d = GNT_N;
        end
        if (frame_oe_q && (frame_o_q == ASRT_N) && (LINK.local_req_narrow_n == IDLE_N)) begin
            req_n_d = IDLE_N;
        end

        // one sequence for both read kinds
        unique case (state_q)
            S_IDLE: begin
                if ((LINK.local_req_narrow_n == ASRT_N) && (status_q == ST_BUS_TERM)) begin
                    req_n_d = ASRT_N;
                    state_d = S_REQ;
                end
            end
            S_REQ: begin
                // start on grant and idle bus
                if ((GNT_N == ASRT_N) && bus_idle) begin
                    grant_n_d = ASRT_N;
                    state_d   = S_GRANT;
                end
            end
            S_GRANT: begin
                if ((LINK.local_req_narrow_n == ASRT_N) && (GNT_N == ASRT_N)) begin
                    status_d = ST_ADDR_LOAD;
                    addr_d   = LINK.local_addr_in;
                    cmd_d    = LINK.local_cmd_byteen_in;
                    len_d    = LINK.local_xfer_len;
                    state_d  = S_LOAD;
                end
            end
            S_LOAD: begin
                frame_o_d  = ASRT_N;
                frame_oe_d = 1'b1;
                ad_o_d     = addr_q;
                ad_oe_d    = 1'b1;
                cbe_o_d    = cmd_q;
                cbe_oe_d   = 1'b1;
                status_d   = ST_BUS_TRANS;
                end_d      = END_NONE;
                cnt_d      = len_q;
                state_d    = S_ADDR;
            end
            S_ADDR: begin
                ad_oe_d   = 1'b0;
                cbe_o_d   = LINK.local_cmd_byteen_in;
                irdy_oe_d = 1'b1;
                irdy_o_d  = LINK.local_ready_n;
                if (LINK.local_ready_n == ASRT_N) begin
                    frame_o_d = IDLE_N;
                end
                state_d = S_DATA;
            end
            S_DATA: begin
                if (phase_done) begin
                    frame_oe_d = 1'b0;
                    cbe_oe_d   = 1'b0;
                    irdy_o_d   = IDLE_N;
                    status_d   = ST_BUS_TERM;
                    end_d      = END_NORMAL;
                    data_d     = LINK.ad;
                    cnt_d      = cnt_q - 1'b1;
                    if (LINK.local_ready_n == ASRT_N) begin
                        strobe_n_d = ASRT_N;
                    end
                    state_d = S_TERM;
                end else if ((irdy_o_q == IDLE_N) && (LINK.local_ready_n == ASRT_N)) begin
                    irdy_o_d  = ASRT_N;
                    frame_o_d = IDLE_N;
                end
            end
            S_TERM: begin
                irdy_oe_d  = 1'b0;
                strobe_n_d = IDLE_N;
                state_d    = S_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            state_q    <= S_IDLE;
            req_n_q    <= IDLE_N;
            grant_n_q  <= IDLE_N;
            status_q   <= ST_BUS_TERM;
            end_q      <= END_NONE;
            addr_q     <= '0;
            cmd_q      <= '0;
            len_q      <= '0;
            cnt_q      <= '0;
            frame_o_q  <= IDLE_N;
            frame_oe_q <= 1'b0;
            irdy_o_q   <= IDLE_N;
            irdy_oe_q  <= 1'b0;
            ad_o_q     <= '0;
            ad_oe_q    <= 1'b0;
            cbe_o_q    <= '0;
            cbe_oe_q   <= 1'b0;
            data_q     <= '0;
            strobe_n_q <= IDLE_N;
        end else if (CE) begin
            state_q    <= state_d;
            req_n_q    <= req_n_d;
            grant_n_q  <= grant_n_d;
            status_q   <= status_d;
            end_q      <= end_d;
            addr_q     <= addr_d;
            cmd_q      <= cmd_d;
            len_q      <= len_d;
            cnt_q      <= cnt_d;
            frame_o_q  <= frame_o_d;
            frame_oe_q <= frame_oe_d;
            irdy_o_q   <= irdy_o_d;
            irdy_oe_q  <= irdy_oe_d;
            ad_o_q     <= ad_o_d;
            ad_oe_q    <= ad_oe_d;
            cbe_o_q    <= cbe_o_d;
            cbe_oe_q   <= cbe_oe_d;
            data_q     <= data_d;
            strobe_n_q <= strobe_n_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign REQ_N                     = req_n_q;
    assign LINK.local_grant_n        = grant_n_q;
    assign LINK.local_phase_state    = status_q;
    assign LINK.remaining_xfer_count = cnt_q;
    assign LINK.local_xfer_strobe_n  = strobe_n_q;
    assign LINK.local_data_out       = data_q;
    assign LINK.end_reason           = end_q;
    assign LINK.frame_n_o            = frame_o_q;
    assign LINK.frame_n_oe           = frame_oe_q;
    assign LINK.irdy_n_o             = irdy_o_q;
    assign LINK.irdy_n_oe            = irdy_oe_q;
    assign LINK.m_ad_o               = ad_o_q;
    assign LINK.m_ad_oe              = ad_oe_q;
    assign LINK.cbe_n_o              = cbe_o_q;
    assign LINK.cbe_n_oe             = cbe_oe_q;

endmodule
`default_nettype wire

/* pmr_pkg.sv */
// Constants, codes and types shared by both ends of the single-read master path.
// Assumes one rising-edge clock shared with the bus and a synchronous active-low reset.
package pmr_pkg;

    localparam int DW       = 32;
    localparam int NW       = 4;
    localparam int LEN_W    = 8;
    localparam int FIFO_DEP = 32;

    // Line levels of the active-low signals
    localparam logic ASRT_N = 1'b0;
    localparam logic IDLE_N = 1'b1;

    localparam logic [NW-1:0] ST_BUS_TERM  = 4'h0;
    localparam logic [NW-1:0] ST_ADDR_LOAD = 4'h1;
    localparam logic [NW-1:0] ST_BUS_TRANS = 4'h2;

    localparam logic [NW-1:0] END_NONE   = 4'h0;
    localparam logic [NW-1:0] END_NORMAL = 4'h1;

    // Read commands on the command lines
    localparam logic [NW-1:0] CMD_IO_READ  = 4'h2;
    localparam logic [NW-1:0] CMD_MEM_READ = 4'h6;

    localparam logic [DW-1:0] AD_ZERO = 32'h0000_0000;

    typedef logic [DW-1:0]    pmr_word_t;
    typedef logic [NW-1:0]    pmr_nib_t;
    typedef logic [LEN_W-1:0] pmr_len_t;

endpackage

/* pmr_link_if.sv */
// Link between the bus master core and its partner (local master plus bus target).
// Resolves the shared bus lines from the enables; undriven active-low lines read high.
`timescale 1ns/100ps
`default_nettype none
interface pmr_link_if;
    import pmr_pkg::*;

    // Local master side
    logic      local_req_narrow_n;
    pmr_word_t local_addr_in;
    pmr_nib_t  local_cmd_byteen_in;
    pmr_len_t  local_xfer_len;
    logic      local_ready_n;
    logic      local_grant_n;
    pmr_nib_t  local_phase_state;
    pmr_len_t  remaining_xfer_count;
    logic      local_xfer_strobe_n;
    pmr_word_t local_data_out;
    pmr_nib_t  end_reason;

    // Bus drivers
    logic      frame_n_o;
    logic      frame_n_oe;
    logic      irdy_n_o;
    logic      irdy_n_oe;
    pmr_word_t m_ad_o;
    logic      m_ad_oe;
    pmr_nib_t  cbe_n_o;
    logic      cbe_n_oe;
    pmr_word_t t_ad_o;
    logic      t_ad_oe;
    logic      devsel_n_o;
    logic      devsel_n_oe;
    logic      trdy_n_o;
    logic      trdy_n_oe;

    // Resolved bus lines
    logic      frame_n;
    logic      irdy_n;
    pmr_word_t ad;
    pmr_nib_t  cbe_n;
    logic      devsel_n;
    logic      trdy_n;

    assign frame_n  = frame_n_oe ? frame_n_o : IDLE_N;
    assign irdy_n   = irdy_n_oe ? irdy_n_o : IDLE_N;
    assign ad       = m_ad_oe ? m_ad_o : (t_ad_oe ? t_ad_o : AD_ZERO);
    assign cbe_n    = cbe_n_oe ? cbe_n_o : '1;
    assign devsel_n = devsel_n_oe ? devsel_n_o : IDLE_N;
    assign trdy_n   = trdy_n_oe ? trdy_n_o : IDLE_N;

    modport dev (
        input  local_req_narrow_n, local_addr_in, local_cmd_byteen_in, local_xfer_len, local_ready_n,
        output local_grant_n, local_phase_state, remaining_xfer_count, local_xfer_strobe_n,
        output local_data_out, end_reason,
        output frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe, m_ad_o, m_ad_oe, cbe_n_o, cbe_n_oe,
        input  frame_n, irdy_n, ad, devsel_n, trdy_n
    );

    modport loc (
        output local_req_narrow_n, local_addr_in, local_cmd_byteen_in, local_xfer_len, local_ready_n,
        input  local_grant_n, local_phase_state, remaining_xfer_count, local_xfer_strobe_n,
        input  local_data_out, end_reason,
        output t_ad_o, t_ad_oe, devsel_n_o, devsel_n_oe, trdy_n_o, trdy_n_oe,
        input  frame_n, irdy_n, ad, cbe_n
    );

endinterface
`default_nettype wire

/* pmr_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; push and pop may happen in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module pmr_fifo #(
    parameter int W   = 32,
    parameter int DEP = 32
) (
    input  wire logic         CLK_SYS,
    input  wire logic         NRST,
    input  wire logic         CE,
    input  wire logic         IN_VALID,
    output logic              IN_READY,
    input  wire logic [W-1:0] IN_DATA,
    output logic              OUT_VALID,
    input  wire logic         OUT_READY,
    output logic      [W-1:0] OUT_DATA
);
    import pmr_pkg::*;

    localparam int AW = $clog2(DEP);

    logic [W-1:0]  mem [DEP];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] wr_d;
    logic [AW-1:0] rd_q;
    logic [AW-1:0] rd_d;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    logic          push;
    logic          pop;

    assign IN_READY  = (cnt_q != (AW+1)'(DEP));
    assign OUT_VALID = (cnt_q != '0);
    assign OUT_DATA  = mem[rd_q];

    always_comb begin
        push  = IN_VALID && IN_READY;
        pop   = OUT_VALID && OUT_READY;
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (CE) begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (CE && push) begin
            mem[wr_q] <= IN_DATA;
        end
    end

endmodule
`default_nettype wire

/* pmr_local_end.sv */
// Partner end: local master issuing single reads into a FIFO, plus the claiming bus target.
// Assumes the core and this end share CLK_SYS; the FIFO drain may stall freely.
`timescale 1ns/100ps
`default_nettype none
module pmr_local_end (
    input  wire logic              CLK_SYS,
    input  wire logic              NRST,
    input  wire logic              CE,
    input  wire logic              START,
    input  wire pmr_pkg::pmr_word_t ADDR,
    input  wire pmr_pkg::pmr_nib_t  CMD,
    input  wire pmr_pkg::pmr_nib_t  BYTEEN,
    input  wire pmr_pkg::pmr_len_t  LEN,
    output logic                   BUSY,
    input  wire pmr_pkg::pmr_word_t TGT_DATA,
    output logic                   OUT_VALID,
    input  wire logic              OUT_READY,
    output pmr_pkg::pmr_word_t     OUT_DATA,
    pmr_link_if.loc                LINK
);
    import pmr_pkg::*;

    // ****************************************
    // Local master
    // ****************************************
    typedef enum logic [1:0] {T_IDLE, T_CLAIM, T_DATA, T_REL} pmr_tgt_t;

    logic      req_n_q;
    logic      req_n_d;
    logic      rdy_n_q;
    logic      rdy_n_d;
    logic      busy_q;
    logic      busy_d;
    pmr_word_t addr_q;
    pmr_word_t addr_d;
    pmr_nib_t  cb_q;
    pmr_nib_t  cb_d;
    pmr_nib_t  be_q;
    pmr_nib_t  be_d;
    pmr_len_t  len_q;
    pmr_len_t  len_d;
    logic      fifo_in_ready;
    pmr_tgt_t  t_q;
    pmr_tgt_t  t_d;
    logic      dev_q;
    logic      dev_d;
    logic      dev_oe_q;
    logic      dev_oe_d;
    logic      trdy_q;
    logic      trdy_d;
    logic      trdy_oe_q;
    logic      trdy_oe_d;
    pmr_word_t tad_q;
    pmr_word_t tad_d;
    logic      tad_oe_q;
    logic      tad_oe_d;

    always_comb begin
        req_n_d = req_n_q;
        rdy_n_d = rdy_n_q;
        busy_d  = busy_q;
        addr_d  = addr_q;
        cb_d    = cb_q;
        be_d    = be_q;
        len_d   = len_q;
        if (START && !busy_q && (LINK.local_phase_state == ST_BUS_TERM)) begin
            req_n_d = ASRT_N;
            busy_d  = 1'b1;
            addr_d  = ADDR;
            cb_d    = CMD;
            be_d    = BYTEEN;
            len_d   = LEN;
        end
        if (LINK.local_phase_state == ST_ADDR_LOAD) begin
            req_n_d = IDLE_N;
            cb_d    = be_q;
        end
        if (busy_q && (rdy_n_q == IDLE_N) && fifo_in_ready && (LINK.local_phase_state != ST_BUS_TERM)) begin
            rdy_n_d = ASRT_N;
        end
        if (LINK.local_xfer_strobe_n == ASRT_N) begin
            rdy_n_d = IDLE_N;
            busy_d  = 1'b0;
        end
    end

    // ****************************************
    // Bus target
    // ****************************************
    always_comb begin
        t_d       = t_q;
        dev_d     = dev_q;
        dev_oe_d  = dev_oe_q;
        trdy_d    = trdy_q;
        trdy_oe_d = trdy_oe_q;
        tad_d     = tad_q;
        tad_oe_d  = tad_oe_q;
        unique case (t_q)
            T_IDLE: begin
                if ((LINK.frame_n == ASRT_N) &&
                    ((LINK.cbe_n == CMD_IO_READ) || (LINK.cbe_n == CMD_MEM_READ))) begin
                    dev_d    = ASRT_N;
                    dev_oe_d = 1'b1;
                    t_d      = T_CLAIM;
                end
            end
            T_CLAIM: begin
                trdy_d    = ASRT_N;
                trdy_oe_d = 1'b1;
                tad_d     = TGT_DATA;
                tad_oe_d  = 1'b1;
                t_d       = T_DATA;
            end
            T_DATA: begin
                if (LINK.irdy_n == ASRT_N) begin
                    dev_d    = IDLE_N;
                    trdy_d   = IDLE_N;
                    tad_oe_d = 1'b0;
                    t_d      = T_REL;
                end
            end
            T_REL: begin
                dev_oe_d  = 1'b0;
                trdy_oe_d = 1'b0;
                t_d       = T_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            req_n_q   <= IDLE_N;
            rdy_n_q   <= IDLE_N;
            busy_q    <= 1'b0;
            addr_q    <= '0;
            cb_q      <= '0;
            be_q      <= '0;
            len_q     <= '0;
            t_q       <= T_IDLE;
            dev_q     <= IDLE_N;
            dev_oe_q  <= 1'b0;
            trdy_q    <= IDLE_N;
            trdy_oe_q <= 1'b0;
            tad_q     <= '0;
            tad_oe_q  <= 1'b0;
        end else if (CE) begin
            req_n_q   <= req_n_d;
            rdy_n_q   <= rdy_n_d;
            busy_q    <= busy_d;
            addr_q    <= addr_d;
            cb_q      <= cb_d;
            be_q      <= be_d;
            len_q     <= len_d;
            t_q       <= t_d;
            dev_q     <= dev_d;
            dev_oe_q  <= dev_oe_d;
            trdy_q    <= trdy_d;
            trdy_oe_q <= trdy_oe_d;
            tad_q     <= tad_d;
            tad_oe_q  <= tad_oe_d;
        end
    end

    // ****************************************
    // Read-data buffer
    // ****************************************
    // capture on strobe
    pmr_fifo #(
        .W   (DW),
        .DEP (FIFO_DEP)
    ) pmr_fifo_i (
        .CLK_SYS   (CLK_SYS),
        .NRST      (NRST),
        .CE        (CE),
        .IN_VALID  (LINK.local_xfer_strobe_n == ASRT_N),
        .IN_READY  (fifo_in_ready),
        .IN_DATA   (LINK.local_data_out),
        .OUT_VALID (OUT_VALID),
        .OUT_READY (OUT_READY),
        .OUT_DATA  (OUT_DATA)
    );

    assign BUSY                     = busy_q;
    assign LINK.local_req_narrow_n  = req_n_q;
    assign LINK.local_ready_n       = rdy_n_q;
    assign LINK.local_addr_in       = addr_q;
    assign LINK.local_cmd_byteen_in = cb_q;
    assign LINK.local_xfer_len      = len_q;
    assign LINK.devsel_n_o          = dev_q;
    assign LINK.devsel_n_oe         = dev_oe_q;
    assign LINK.trdy_n_o            = trdy_q;
    assign LINK.trdy_n_oe           = trdy_oe_q;
    assign LINK.t_ad_o              = tad_q;
    assign LINK.t_ad_oe             = tad_oe_q;

endmodule
`default_nettype wire

/* pmr_checker.sv */
// Checker of the single-read handshake between the core and the local end.
// Assumes one clock, synchronous active-low reset and clock enable held high.
`timescale 1ns/100ps
`default_nettype none
module pmr_checker (
    input wire logic              CLK_SYS,
    input wire logic              NRST,
    input wire logic              REQ_N,
    input wire logic              GNT_N,
    input wire logic              local_req_narrow_n,
    input wire logic              local_ready_n,
    input wire logic              local_grant_n,
    input wire pmr_pkg::pmr_nib_t local_phase_state,
    input wire pmr_pkg::pmr_len_t remaining_xfer_count,
    input wire pmr_pkg::pmr_len_t local_xfer_len,
    input wire logic              local_xfer_strobe_n,
    input wire pmr_pkg::pmr_nib_t end_reason,
    input wire logic              frame_n,
    input wire logic              irdy_n,
    input wire logic              trdy_n,
    input wire logic              devsel_n,
    input wire logic              m_ad_oe
);
    import pmr_pkg::*;
    // ****************************************
    // Sequence relations
    // ****************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    bus_req_a: assert property ((!local_req_narrow_n && REQ_N && local_phase_state == ST_BUS_TERM)
        |=> !REQ_N) else $error("bus request not raised");
    addr_load_a: assert property ((!local_req_narrow_n && !GNT_N && !local_grant_n
        && local_phase_state == ST_BUS_TERM) |=> local_phase_state == ST_ADDR_LOAD) else $error("no address load");
    addr_phase_a: assert property (local_phase_state == ST_ADDR_LOAD |=> (!frame_n && m_ad_oe
        && local_phase_state == ST_BUS_TRANS && remaining_xfer_count == $past(local_xfer_len)))
        else $error("address phase wrong");
    turn_around_a: assert property ((!frame_n && m_ad_oe && !local_ready_n) |=> (!m_ad_oe && !irdy_n && frame_n))
        else $error("turnaround wrong");
    req_drop_a: assert property ((!frame_n && local_req_narrow_n) |=> REQ_N) else $error("bus request held");
    grant_follow_a: assert property (($rose(GNT_N) && !local_grant_n) |=> local_grant_n)
        else $error("local grant held");
    phase_done_a: assert property ((!irdy_n && !trdy_n) |=> (local_phase_state == ST_BUS_TERM && irdy_n
        && frame_n && end_reason == END_NORMAL && remaining_xfer_count == $past(remaining_xfer_count) - 8'h01))
        else $error("termination wrong");
    xfer_strobe_a: assert property ((!irdy_n && !trdy_n && !local_ready_n) |=> !local_xfer_strobe_n
        ##1 (local_xfer_strobe_n && irdy_n)) else $error("strobe wrong");
    state_order_a: assert property (local_phase_state == ST_BUS_TRANS |-> $past(local_phase_state) != ST_BUS_TERM)
        else $error("status order wrong");
    tgt_claim_a: assert property ((!frame_n && m_ad_oe) |=> (!devsel_n ##1 !trdy_n))
        else $error("target claim wrong");
    cover property (local_phase_state == ST_ADDR_LOAD);
    cover property (!irdy_n && !trdy_n);
    cover property (!local_xfer_strobe_n);
endmodule
`default_nettype wire

/* test_pci_master_single_read_32.sv */
// Testbench: core and local end joined by the link, single reads issued through the local end.
// Assumes the arbiter grants one cycle after each bus request; the drain is stalled as the tests command.
`timescale 1ns/100ps
`default_nettype none
module test_pci_master_single_read_32;
    import pmr_pkg::*;
    // ****************************************
    // Bench
    // ****************************************
    logic      CLK_SYS, NRST, GNT_N, REQ_N, START, BUSY, OUT_VALID, OUT_READY;
    pmr_word_t ADDR, TGT_DATA, OUT_DATA, ad_seen;
    pmr_nib_t  CMD, BYTEEN, cmd_seen, ben_seen;
    pmr_len_t  LEN;
    pmr_word_t exp_q[$];
    int        n_errors, n_compared;
    pmr_link_if lk ();
    pmr_core pmr_core_i (.CLK_SYS(CLK_SYS), .NRST(NRST), .CE(1'b1), .GNT_N(GNT_N), .REQ_N(REQ_N), .LINK(lk.dev));
    pmr_local_end pmr_local_end_i (.CLK_SYS(CLK_SYS), .NRST(NRST), .CE(1'b1), .START(START), .ADDR(ADDR),
        .CMD(CMD), .BYTEEN(BYTEEN), .LEN(LEN), .BUSY(BUSY), .TGT_DATA(TGT_DATA), .OUT_VALID(OUT_VALID),
        .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .LINK(lk.loc));
    pmr_checker pmr_checker_i (.CLK_SYS(CLK_SYS), .NRST(NRST), .REQ_N(REQ_N), .GNT_N(GNT_N),
        .local_req_narrow_n(lk.local_req_narrow_n), .local_ready_n(lk.local_ready_n),
        .local_grant_n(lk.local_grant_n), .local_phase_state(lk.local_phase_state),
        .remaining_xfer_count(lk.remaining_xfer_count), .local_xfer_len(lk.local_xfer_len),
        .local_xfer_strobe_n(lk.local_xfer_strobe_n), .end_reason(lk.end_reason), .frame_n(lk.frame_n),
        .irdy_n(lk.irdy_n), .trdy_n(lk.trdy_n), .devsel_n(lk.devsel_n), .m_ad_oe(lk.m_ad_oe));
    initial begin
        CLK_SYS = 1'b0;
        forever #20 CLK_SYS = ~CLK_SYS;
    end
    // Arbiter grants one cycle after the request
    always @(posedge CLK_SYS) GNT_N <= #1 REQ_N;
    always @(posedge CLK_SYS) begin
        if (!lk.frame_n && lk.m_ad_oe) begin
            cmd_seen <= lk.cbe_n;
            ad_seen <= lk.ad;
        end
        if (!lk.irdy_n)
            ben_seen <= lk.cbe_n;
    end
    task automatic cmp(input pmr_word_t got, input pmr_word_t exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input int i, input bit wait_done);
        @(posedge CLK_SYS) #1;
        START = 1'b1;
        ADDR = {16'h4000, 16'(i * 4)};
        CMD = i[0] ? CMD_MEM_READ : CMD_IO_READ;
        BYTEEN = i[3:0];
        LEN = 8'(i + 1);
        TGT_DATA = {8'ha5, 24'(i)};
        exp_q.push_back(TGT_DATA);
        @(posedge CLK_SYS) #1;
        START = 1'b0;
        for (int k = 0; k < 40 && wait_done && BUSY !== 1'b0; k++) @(posedge CLK_SYS) #1;
        if (wait_done) begin
            cmp(32'(BUSY), 32'h0);
            cmp(ad_seen, ADDR);
            cmp(32'(cmd_seen), 32'(CMD));
            cmp(32'(ben_seen), 32'(BYTEEN));
            cmp(lk.local_data_out, TGT_DATA);
            cmp(32'(lk.remaining_xfer_count), 32'(LEN - 8'h01));
            cmp(32'(lk.end_reason), 32'(END_NORMAL));
        end
    endtask
    task automatic drain();
        while (exp_q.size() > 0) begin
            if (OUT_VALID !== 1'b1) begin
                OUT_READY = 1'b0;
                for (int k = 0; k < 60 && OUT_VALID !== 1'b1; k++) @(posedge CLK_SYS) #1;
            end
            cmp(32'(OUT_VALID), 32'h1);
            cmp(OUT_DATA, exp_q.pop_front());
            OUT_READY = 1'b1;
            @(posedge CLK_SYS) #1;
        end
        OUT_READY = 1'b0;
    endtask
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
    initial begin
        {NRST, START, OUT_READY, n_errors, n_compared} = '0;
        {ADDR, CMD, BYTEEN, LEN, TGT_DATA} = '0;
        repeat (2) @(posedge CLK_SYS);
        #1 NRST = 1'b1;
        // Fill the buffer with back-to-back reads of both commands
        for (int i = 0; i < 32; i++) rd(i, 1'b1);
        cmp(32'(OUT_VALID), 32'h1);
        // Buffer full: the next read must wait for room
        rd(32, 1'b0);
        repeat (30) @(posedge CLK_SYS);
        #1 cmp(32'(BUSY), 32'h1);
        drain();
        summarize();
    end
endmodule
`default_nettype wire
